// ===== verilog/t1_status_device.sv
// latched status and receive information registers with density monitors
// Notes on behaviour
// - events and alarms set their latched bit
// - bit stays set until read and cleared
// - host writes mask byte before reading
// - mask one loads current state, drops old
// - mask zero leaves readable bit unchanged
// - host reads same register right after mask
// - host writes back read value and mask
// - status one and two drive interrupt outputs
// - each status bit maskable from its interrupt
// - flags for eight and sixteen received zeros
// - frame bit error sets its flag
// - elastic store full, empty and slip flags
// - two-bit field reports received level
// - flag more than fifteen consecutive zeros
// - flag windows holding too few ones
// - transmit violation bit 0, receive bit 1
// - enforcer bends transmit stream when enabled
// - enforcer should stay off under B8ZS
`timescale 1ns/1ps
`default_nettype none
module t1_status_device import t1_status_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// control port
	t1_port_if.dev port,
	// asynchronous event levels
	input wire logic [7:0] status_one_in,
	input wire logic [7:0] status_two_in,
	input wire logic [7:0] rx_info_in,
	input wire logic [3:0] tx_info_in,
	input wire logic [1:0] rx_level_in,
	// serial streams
	input wire logic rx_bit,
	input wire logic rx_bit_valid,
	input wire logic tx_bit,
	input wire logic tx_bit_valid,
	output logic tx_line_bit,
	output logic tx_line_valid,
	output logic enforcer_on
);
	localparam int SYNC_W = 30;
	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_out;
	logic [7:0] status_one_s;
	logic [7:0] status_two_s;
	logic [7:0] rx_info_s;
	logic [3:0] tx_info_s;
	logic [1:0] rx_level_s;
	logic [7:0] lat [NUM_LATCHED];
	logic [7:0] view [NUM_LATCHED];
	logic [7:0] ev [NUM_LATCHED];
	logic [7:0] irq_mask_one;
	logic [7:0] irq_mask_two;
	logic [7:0] common_control_three;
	logic hit_latched;
	logic [1:0] hit_sel;
	logic rx_viol;
	logic tx_viol;
	logic rx_eight;
	logic rx_sixteen;

	// two-stage synchroniser for the event levels
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_meta <= '0;
			sync_out <= '0;
		end else begin
			sync_meta <= {status_one_in, status_two_in, rx_info_in, tx_info_in, rx_level_in};
			sync_out <= sync_meta;
		end
	end

	assign {status_one_s, status_two_s, rx_info_s, tx_info_s, rx_level_s} = sync_out;

	// receive stream: monitor only
	density_monitor rx_mon (
		.mclk(mclk),
		.rst_n(rst_n),
		.enforce(1'b0),
		.bit_in(rx_bit),
		.bit_valid(rx_bit_valid),
		.bit_out(),
		.bit_out_valid(),
		.violation(rx_viol),
		.eight_zero(rx_eight),
		.sixteen_zero(rx_sixteen)
	);

	// transmit stream: monitor checks the stream as sent
	density_monitor tx_mon (
		.mclk(mclk),
		.rst_n(rst_n),
		.enforce(common_control_three[ENFORCER_BIT]),
		.bit_in(tx_bit),
		.bit_valid(tx_bit_valid),
		.bit_out(tx_line_bit),
		.bit_out_valid(tx_line_valid),
		.violation(tx_viol),
		.eight_zero(),
		.sixteen_zero()
	);

	// event vectors for the four latched registers
	always_comb begin
		ev[SEL_STATUS_ONE] = status_one_s;
		ev[SEL_STATUS_TWO] = status_two_s;
		ev[SEL_RX_INFO_ONE] = rx_info_s
			| (8'(rx_eight) << EIGHT_ZERO_BIT)
			| (8'(rx_sixteen) << SIXTEEN_ZERO_BIT);
		ev[SEL_RX_INFO_TWO] = (8'(tx_info_s) << TX_STORE_LO_BIT)
			| (8'(rx_viol) << RX_DENSITY_BIT)
			| (8'(tx_viol) << TX_DENSITY_BIT);
	end

	// decode of the latched registers
	always_comb begin
		hit_latched = 1'b1;
		hit_sel = SEL_STATUS_ONE;
		case (port.addr)
			ADDR_STATUS_ONE: hit_sel = SEL_STATUS_ONE;
			ADDR_STATUS_TWO: hit_sel = SEL_STATUS_TWO;
			ADDR_RX_INFO_ONE: hit_sel = SEL_RX_INFO_ONE;
			ADDR_RX_INFO_TWO: hit_sel = SEL_RX_INFO_TWO;
			default: hit_latched = 1'b0;
		endcase
	end

	// latch and readable copy; a masked write moves latched into view
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int s = 0; s < NUM_LATCHED; s++) begin
				lat[s] <= REG_RESET;
				view[s] <= REG_RESET;
			end
		end else begin
			for (int s = 0; s < NUM_LATCHED; s++) begin
				if (port.wr && hit_latched && hit_sel == 2'(s)) begin
					// set wins over the clear in the same cycle
					lat[s] <= (lat[s] & ~port.wdata) | ev[s];
					view[s] <= (view[s] & ~port.wdata) | ((lat[s] | ev[s]) & port.wdata);
				end else begin
					lat[s] <= lat[s] | ev[s];
				end
			end
		end
	end

	// writable control registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_one <= REG_RESET;
			irq_mask_two <= REG_RESET;
			common_control_three <= REG_RESET;
		end else if (port.wr) begin
			case (port.addr)
				ADDR_IRQ_MASK_ONE: irq_mask_one <= port.wdata;
				ADDR_IRQ_MASK_TWO: irq_mask_two <= port.wdata;
				ADDR_COMMON_CONTROL_THREE: common_control_three <= port.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			enforcer_on <= 1'b0;
		else
			enforcer_on <= common_control_three[ENFORCER_BIT];
	end

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port.rdata <= REG_RESET;
		end else if (port.rd) begin
			case (port.addr)
				ADDR_STATUS_ONE: port.rdata <= view[SEL_STATUS_ONE];
				ADDR_STATUS_TWO: port.rdata <= view[SEL_STATUS_TWO];
				ADDR_RX_INFO_ONE: port.rdata <= view[SEL_RX_INFO_ONE];
				ADDR_RX_INFO_TWO: port.rdata <= (view[SEL_RX_INFO_TWO] & 8'h3f)
					| (8'(rx_level_s) << RX_LEVEL_LO_BIT);
				ADDR_IRQ_MASK_ONE: port.rdata <= irq_mask_one;
				ADDR_IRQ_MASK_TWO: port.rdata <= irq_mask_two;
				ADDR_COMMON_CONTROL_THREE: port.rdata <= common_control_three;
				default: port.rdata <= REG_RESET;
			endcase
		end else begin
			port.rdata <= REG_RESET;
		end
	end

	// interrupt outputs; receive information registers never interrupt
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port.irq_out_one <= 1'b0;
			port.irq_out_two <= 1'b0;
		end else begin
			port.irq_out_one <= |((lat[SEL_STATUS_ONE] | view[SEL_STATUS_ONE]) & irq_mask_one);
			port.irq_out_two <= |((lat[SEL_STATUS_TWO] | view[SEL_STATUS_TWO]) & irq_mask_two);
		end
	end
endmodule : t1_status_device
`default_nettype wire

// ===== verilog/t1_status_pkg.sv
// constants shared by the status latch device, its host and the density monitor
`default_nettype none
package t1_status_pkg;
	// device register byte addresses
	localparam logic [7:0] ADDR_IRQ_MASK_ONE = 8'h16;
	localparam logic [7:0] ADDR_IRQ_MASK_TWO = 8'h17;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h20;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h21;
	localparam logic [7:0] ADDR_RX_INFO_ONE = 8'h22;
	localparam logic [7:0] ADDR_COMMON_CONTROL_THREE = 8'h30;
	localparam logic [7:0] ADDR_RX_INFO_TWO = 8'h31;
	localparam logic [7:0] REG_RESET = 8'h00;
	// latched register slots
	localparam int NUM_LATCHED = 4;
	localparam logic [1:0] SEL_STATUS_ONE = 2'h0;
	localparam logic [1:0] SEL_STATUS_TWO = 2'h1;
	localparam logic [1:0] SEL_RX_INFO_ONE = 2'h2;
	localparam logic [1:0] SEL_RX_INFO_TWO = 2'h3;
	// field positions
	localparam int EIGHT_ZERO_BIT = 6;
	localparam int SIXTEEN_ZERO_BIT = 5;
	localparam int RX_LEVEL_LO_BIT = 6;
	localparam int RX_DENSITY_BIT = 1;
	localparam int TX_DENSITY_BIT = 0;
	localparam int TX_STORE_LO_BIT = 2;
	localparam int ENFORCER_BIT = 3;
	// density rules and zero runs
	localparam int DM_MAX_N = 23;
	localparam int DM_WIN_UNIT = 8;
	localparam int DM_ZERO_LIMIT = 15;
	localparam int ZRUN_W = 5;
	localparam logic [ZRUN_W-1:0] EIGHT_ZERO_RUN = 5'h08;
	localparam logic [ZRUN_W-1:0] SIXTEEN_ZERO_RUN = 5'h10;
	// host software port
	localparam logic [2:0] HOST_TARGET = 3'h0;
	localparam logic [2:0] HOST_DATA = 3'h1;
	localparam logic [2:0] HOST_COMMAND = 3'h2;
	localparam logic [2:0] HOST_RESULT = 3'h3;
	localparam logic [2:0] HOST_STATUS = 3'h4;
	localparam int CMD_POLL_BIT = 0;
	localparam int CMD_WRITE_BIT = 1;
	localparam int CMD_READ_BIT = 2;
	typedef enum logic [2:0] {
		H_IDLE, H_MASK, H_READ, H_TAKE, H_BACK, H_WRITE
	} host_state_t;
endpackage : t1_status_pkg
`default_nettype wire

// ===== verilog/t1_port_if.sv
// parallel control port between the status device and its host
`timescale 1ns/1ps
`default_nettype none
interface t1_port_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic irq_out_one;
	logic irq_out_two;
	modport dev (input addr, wdata, wr, rd, output rdata, irq_out_one, irq_out_two);
	modport host (output addr, wdata, wr, rd, input rdata, irq_out_one, irq_out_two);
endinterface : t1_port_if
`default_nettype wire

// ===== verilog/density_monitor.sv
// ones-density monitor with optional enforcer for one serial stream
`timescale 1ns/1ps
`default_nettype none
module density_monitor import t1_status_pkg::*; #(
	parameter int MAX_N = DM_MAX_N,
	parameter int UNIT = DM_WIN_UNIT,
	parameter int ZLIM = DM_ZERO_LIMIT
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// stream in
	input wire logic enforce,
	input wire logic bit_in,
	input wire logic bit_valid,
	// stream out and flags
	output logic bit_out,
	output logic bit_out_valid,
	output logic violation,
	output logic eight_zero,
	output logic sixteen_zero
);
	localparam int DEPTH = UNIT * (MAX_N + 1);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int AW = CW + 1;
	logic [DEPTH-1:0] hist;
	logic [CW-1:0] ones [1:MAX_N];
	logic [CW-1:0] seen;
	logic [ZRUN_W-1:0] zrun;
	logic viol_zero;
	logic viol_one;
	logic b;

	// trial of a zero and a one against every window
	always_comb begin
		viol_zero = (int'(zrun) >= ZLIM);
		viol_one = 1'b0;
		for (int n = 1; n <= MAX_N; n++) begin
			if (int'(seen) >= UNIT * (n + 1) - 1) begin
				if ({1'b0, ones[n]} < AW'(n) + AW'(hist[UNIT*(n+1)-1]))
					viol_zero = 1'b1;
				if ({1'b0, ones[n]} + AW'(1) < AW'(n) + AW'(hist[UNIT*(n+1)-1]))
					viol_one = 1'b1;
			end
		end
		b = bit_in | (enforce & viol_zero);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hist <= '0;
			seen <= '0;
			for (int n = 1; n <= MAX_N; n++)
				ones[n] <= '0;
		end else if (bit_valid) begin
			hist <= {hist[DEPTH-2:0], b};
			if (int'(seen) < DEPTH)
				seen <= seen + CW'(1);
			for (int n = 1; n <= MAX_N; n++)
				ones[n] <= ones[n] + CW'(b) - CW'(hist[UNIT*(n+1)-1]);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			zrun <= '0;
		end else if (bit_valid) begin
			if (b)
				zrun <= '0;
			else if (zrun != SIXTEEN_ZERO_RUN)
				zrun <= zrun + ZRUN_W'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bit_out <= 1'b0;
			bit_out_valid <= 1'b0;
			violation <= 1'b0;
			eight_zero <= 1'b0;
			sixteen_zero <= 1'b0;
		end else begin
			bit_out <= bit_valid ? b : bit_out;
			bit_out_valid <= bit_valid;
			violation <= bit_valid & (b ? viol_one : viol_zero);
			eight_zero <= bit_valid & ~b & (zrun == EIGHT_ZERO_RUN - 5'h01);
			sixteen_zero <= bit_valid & ~b & (zrun == SIXTEEN_ZERO_RUN - 5'h01);
		end
	end
endmodule : density_monitor
`default_nettype wire

// ===== verilog/t1_status_host.sv
// host end: runs the write-read-write poll on the control port
`timescale 1ns/1ps
`default_nettype none
module t1_status_host import t1_status_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// control port
	t1_port_if.host port,
	// software port
	input wire logic [2:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [7:0] sw_rdata
);
	host_state_t state;
	logic [7:0] target;
	logic [7:0] data;
	logic [7:0] result;
	logic start;
	logic polling;

	assign start = sw_wr && sw_addr == HOST_COMMAND && state == H_IDLE;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			target <= REG_RESET;
			data <= REG_RESET;
		end else if (sw_wr && state == H_IDLE) begin
			if (sw_addr == HOST_TARGET)
				target <= sw_wdata;
			if (sw_addr == HOST_DATA)
				data <= sw_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= H_IDLE;
			result <= REG_RESET;
			port.addr <= REG_RESET;
			port.wdata <= REG_RESET;
			port.wr <= 1'b0;
			port.rd <= 1'b0;
			polling <= 1'b0;
		end else begin
			port.wr <= 1'b0;
			port.rd <= 1'b0;
			case (state)
				H_IDLE: begin
					if (start && sw_wdata[CMD_POLL_BIT]) begin
						port.addr <= target;
						port.wdata <= data;
						port.wr <= 1'b1;
						polling <= 1'b1;
						state <= H_MASK;
					end else if (start && sw_wdata[CMD_WRITE_BIT]) begin
						port.addr <= target;
						port.wdata <= data;
						port.wr <= 1'b1;
						state <= H_WRITE;
					end else if (start && sw_wdata[CMD_READ_BIT]) begin
						port.addr <= target;
						port.rd <= 1'b1;
						polling <= 1'b0;
						state <= H_READ;
					end
				end
				H_MASK: begin
					port.rd <= 1'b1;
					state <= H_READ;
				end
				H_READ: state <= H_TAKE;
				H_TAKE: begin
					// every poll ends in a write-back, even with an empty mask
					if (polling) begin
						result <= port.rdata & data;
						port.wdata <= port.rdata & data;
						port.wr <= 1'b1;
						state <= H_BACK;
					end else begin
						result <= port.rdata;
						state <= H_IDLE;
					end
				end
				H_BACK: state <= H_IDLE;
				H_WRITE: state <= H_IDLE;
				default: state <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sw_rdata <= REG_RESET;
		end else if (sw_rd) begin
			case (sw_addr)
				HOST_TARGET: sw_rdata <= target;
				HOST_DATA: sw_rdata <= data;
				HOST_RESULT: sw_rdata <= result;
				HOST_STATUS: sw_rdata <= {5'h00, port.irq_out_two, port.irq_out_one,
					state != H_IDLE};
				default: sw_rdata <= REG_RESET;
			endcase
		end else begin
			sw_rdata <= REG_RESET;
		end
	end
endmodule : t1_status_host
`default_nettype wire

// ===== test/t1_port_checker.sv
// concurrent checks on the control port between host and device
`timescale 1ns/1ps
`default_nettype none
module t1_port_checker import t1_status_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// port signals
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq_out_one,
	input wire logic irq_out_two
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [7:0] mask_one;
	logic [7:0] mask_two;
	wire logic lat_sel = addr == ADDR_STATUS_ONE || addr == ADDR_STATUS_TWO
		|| addr == ADDR_RX_INFO_ONE || addr == ADDR_RX_INFO_TWO;
	wire logic mapped = lat_sel || addr == ADDR_IRQ_MASK_ONE || addr == ADDR_IRQ_MASK_TWO
		|| addr == ADDR_COMMON_CONTROL_THREE;
	// shadow of the interrupt masks
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mask_one <= 8'h00;
			mask_two <= 8'h00;
		end else if (wr) begin
			if (addr == ADDR_IRQ_MASK_ONE) mask_one <= wdata;
			if (addr == ADDR_IRQ_MASK_TWO) mask_two <= wdata;
		end
	end
	chk_strobe_excl:
		assert property (!(wr && rd)) else $error("write and read strobes together");
	chk_rdata_idle:
		assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data outside answer");
	chk_read_after_mask:
		assert property (rd && lat_sel |-> $past(wr) && $past(addr) == addr)
		else $error("latched read without mask write");
	chk_write_back:
		assert property (rd && lat_sel |-> ##2 wr && addr == $past(addr, 2)
			&& wdata == ($past(rdata) & $past(wdata, 3))) else $error("bad write back");
	chk_unmapped_read:
		assert property (rd && !mapped |=> rdata == 8'h00) else $error("unmapped read not zero");
	chk_irq_one_mask:
		assert property (irq_out_one |-> $past(mask_one) != 8'h00) else $error("irq one unmasked");
	chk_irq_two_mask:
		assert property (irq_out_two |-> $past(mask_two) != 8'h00) else $error("irq two unmasked");
	chk_irq_one_release:
		assert property (wr && addr == ADDR_IRQ_MASK_ONE && wdata == 8'h00 |-> ##2 !irq_out_one)
		else $error("irq one held after masking");
	chk_irq_two_release:
		assert property (wr && addr == ADDR_IRQ_MASK_TWO && wdata == 8'h00 |-> ##2 !irq_out_two)
		else $error("irq two held after masking");
	cover property (rd && lat_sel);
	cover property ($rose(irq_out_one));
	cover property ($rose(irq_out_two));
endmodule : t1_port_checker
`default_nettype wire

// ===== test/t1_status_latch_density_monitor_bench.sv
// bench for the status device and its host joined on the control port
`timescale 1ns/1ps
`default_nettype none
module t1_status_latch_density_monitor_bench import t1_status_pkg::*; ();
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] status_one_in = 8'h00, status_two_in = 8'h00, rx_info_in = 8'h00;
	logic [3:0] tx_info_in = 4'h0;
	logic [1:0] rx_level_in = 2'h0;
	logic rx_bit = 1'b0, rx_bit_valid = 1'b0, tx_bit = 1'b0, tx_bit_valid = 1'b0;
	logic tx_line_bit, tx_line_valid, enforcer_on;
	logic [2:0] sw_addr = 3'h0;
	logic [7:0] sw_wdata = 8'h00;
	logic sw_wr = 1'b0, sw_rd = 1'b0, rd_seen = 1'b0;
	logic [7:0] sw_rdata, p, lv;
	logic [7:0] notes[$];
	logic [7:0] lat_addr [4] = '{ADDR_STATUS_ONE, ADDR_STATUS_TWO, ADDR_RX_INFO_ONE,
		ADDR_RX_INFO_TWO};
	int err_total = 0, num_checks = 0, cycles = 0, zrun = 0, zmax = 0;
	t1_port_if port_bus ();
	t1_status_device t1_status_device_inst (.mclk, .rst_n, .port(port_bus), .status_one_in,
		.status_two_in, .rx_info_in, .tx_info_in, .rx_level_in, .rx_bit, .rx_bit_valid,
		.tx_bit, .tx_bit_valid, .tx_line_bit, .tx_line_valid, .enforcer_on);
	t1_status_host t1_status_host_inst (.mclk, .rst_n, .port(port_bus), .sw_addr, .sw_wdata,
		.sw_wr, .sw_rd, .sw_rdata);
	t1_port_checker t1_port_checker_inst (.mclk, .rst_n, .addr(port_bus.addr),
		.wdata(port_bus.wdata), .wr(port_bus.wr), .rd(port_bus.rd), .rdata(port_bus.rdata),
		.irq_out_one(port_bus.irq_out_one), .irq_out_two(port_bus.irq_out_two));
	initial begin
		forever #5 mclk = ~mclk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		if (err_total == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	// one software strobe; a read notes its expected answer
	task automatic sw_op(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= w;
		sw_rd <= !w;
		if (!w) notes.push_back(d);
		@(posedge mclk);
		sw_wr <= 1'b0;
		sw_rd <= 1'b0;
	endtask : sw_op
	task automatic run(input logic [7:0] cmd, input logic [7:0] target, input logic [7:0] data);
		sw_op(1'b1, HOST_TARGET, target);
		sw_op(1'b1, HOST_DATA, data);
		sw_op(1'b1, HOST_COMMAND, cmd);
		repeat (8) @(posedge mclk);
	endtask : run
	task automatic poll(input logic [7:0] target, input logic [7:0] mask, input logic [7:0] exp);
		run(8'h01, target, mask);
		sw_op(1'b0, HOST_RESULT, exp);
	endtask : poll
	task automatic pulse(input int sel, input logic [7:0] v);
		@(posedge mclk);
		case (sel)
			0: status_one_in <= v;
			1: status_two_in <= v;
			2: rx_info_in <= v;
			default: tx_info_in <= v[3:0];
		endcase
		repeat (2) @(posedge mclk);
		status_one_in <= 8'h00;
		status_two_in <= 8'h00;
		rx_info_in <= 8'h00;
		tx_info_in <= 4'h0;
		repeat (4) @(posedge mclk);
	endtask : pulse
	task automatic feed(input logic b, input int n);
		repeat (n) begin
			@(posedge mclk);
			rx_bit <= b;
			tx_bit <= b;
			rx_bit_valid <= 1'b1;
			tx_bit_valid <= 1'b1;
		end
	endtask : feed
	task automatic halt();
		@(posedge mclk);
		rx_bit_valid <= 1'b0;
		tx_bit_valid <= 1'b0;
	endtask : halt
	// answer watcher, zero-run tracker and hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			end_of_test();
		end else begin
			if (rd_seen) check(sw_rdata, notes.pop_front(), "sw_rdata");
			rd_seen <= sw_rd;
			if (tx_line_valid) zrun = tx_line_bit ? 0 : zrun + 1;
			if (enforcer_on && zrun > zmax) zmax = zrun;
		end
	end
	initial begin
		void'($urandom(29));
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		run(8'h04, ADDR_IRQ_MASK_ONE, 8'h00);
		sw_op(1'b0, HOST_RESULT, REG_RESET);
		run(8'h02, ADDR_IRQ_MASK_TWO, 8'h5a);
		run(8'h04, ADDR_IRQ_MASK_TWO, 8'h00);
		sw_op(1'b0, HOST_RESULT, 8'h5a);
		run(8'h02, ADDR_IRQ_MASK_TWO, 8'h00);
		run(8'h04, 8'h3f, 8'h00);
		sw_op(1'b0, HOST_RESULT, 8'h00);
		// each latched register, partial masks, every level code
		for (int s = 0; s < 4; s++) begin
			rx_level_in <= s[1:0];
			p = 8'($urandom);
			lv = (s == 3) ? {s[1:0], p[3:0], 2'b00} : p;
			pulse(s, p);
			poll(ADDR_RX_INFO_TWO, 8'hc0, {s[1:0], 6'h00});
			poll(lat_addr[s], 8'h0f, lv & 8'h0f);
			poll(lat_addr[s], 8'hf0, lv & 8'hf0);
			poll(lat_addr[s], 8'hff, lv & 8'hc0 & {8{s == 3}});
		end
		for (int k = 0; k < 2; k++) begin
			run(8'h02, ADDR_IRQ_MASK_ONE + k[7:0], 8'h01);
			pulse(k, 8'h02);
			sw_op(1'b0, HOST_STATUS, 8'h00);
			pulse(k, 8'h01);
			sw_op(1'b0, HOST_STATUS, 8'h02 << k);
			poll(lat_addr[k], 8'hff, 8'h03);
			sw_op(1'b0, HOST_STATUS, 8'h00);
			pulse(k, 8'h01);
			run(8'h02, ADDR_IRQ_MASK_ONE + k[7:0], 8'h00);
			sw_op(1'b0, HOST_STATUS, 8'h00);
			poll(lat_addr[k], 8'hff, 8'h01);
		end
		feed(1'b0, 16);
		halt();
		poll(ADDR_RX_INFO_ONE, 8'h60, 8'h60);
		poll(ADDR_RX_INFO_TWO, 8'h03, 8'h03);
		feed(1'b1, 1);
		feed(1'b0, 7);
		feed(1'b1, 1);
		feed(1'b0, 7);
		halt();
		poll(ADDR_RX_INFO_ONE, 8'h60, 8'h00);
		poll(ADDR_RX_INFO_TWO, 8'h03, 8'h03);
		run(8'h02, ADDR_COMMON_CONTROL_THREE, 8'h08);
		check({7'h0, enforcer_on}, 8'h01, "enforcer_on");
		repeat (300) feed($urandom % 16 == 0, 1);
		halt();
		repeat (4) @(posedge mclk);
		check({7'h0, zmax > 15}, 8'h00, "zero run");
		end_of_test();
	end
endmodule : t1_status_latch_density_monitor_bench
`default_nettype wire
